// ==== common/char_display_pkg.sv ====
package char_display_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned REF_OSC_KHZ    = 250;
	localparam int unsigned CLEAR_TIME_NS  = 6200000;
	// longest time: rounded down
	localparam int unsigned CLEAR_CYCLES   = CLEAR_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned EXEC_TIME_NS   = 40;
	// least time: rounded up
	localparam int unsigned EXEC_CYCLES    =
		(EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// register map and bus answers
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W         = 12;
	localparam logic [11:0] OFS_INSTR      = 12'h000;
	localparam logic [11:0] OFS_DATA       = 12'h004;
	localparam logic [11:0] OFS_CFG        = 12'h008;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	// ----------------------------------------------------------------
	// memories, codes and field values
	// ----------------------------------------------------------------
	localparam int unsigned DISPLAY_DATA_RAM_DEPTH    = 128;
	localparam int unsigned GLYPH_DEPTH    = 64;
	localparam logic [7:0]  BLANK_CODE     = 8'h20;
	localparam logic [7:0]  CMD_CLEAR      = 8'h01;
	localparam logic [3:0]  ROWS_TALL      = 4'ha;
	localparam logic [3:0]  ROWS_SHORT     = 4'h8;
	localparam logic [1:0]  FT_NONE        = 2'h3;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       bus_width_select;
		logic       line_count;
		logic       glyph_height;
		logic [1:0] font_table;
		logic       graphic_or_text_mode;
		logic       internal_supply_on;
		logic       display_on;
		logic       cursor_on;
		logic       blink_on;
		logic       step_direction;
		logic       shift_on_entry;
	} disp_cfg_s;

	localparam disp_cfg_s RST_CFG = '{
		bus_width_select:     1'b1,
		line_count:           1'b0,
		glyph_height:         1'b0,
		font_table:           2'h0,
		graphic_or_text_mode: 1'b0,
		internal_supply_on:   1'b0,
		display_on:           1'b0,
		cursor_on:            1'b0,
		blink_on:             1'b0,
		step_direction:       1'b1,
		shift_on_entry:       1'b0
	};

	typedef enum logic [1:0] {EX_IDLE, EX_CLEAR, EX_BUSY} exec_state_e;

endpackage : char_display_pkg

// ==== hdl/char_display_instruction_decoder.sv ====
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
module char_display_instruction_decoder #(
	parameter int unsigned OSC_KHZ      = char_display_pkg::REF_OSC_KHZ,
	parameter int unsigned CLEAR_CYCLES = char_display_pkg::CLEAR_CYCLES,
	parameter int unsigned EXEC_CYCLES  = char_display_pkg::EXEC_CYCLES
) (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [11:0]                 awaddr,
	input  wire logic [2:0]                  awprot,
	input  wire logic                        awvalid,
	output logic                             awready,
	input  wire logic [31:0]                 wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	output logic [1:0]                       bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	input  wire logic [11:0]                 araddr,
	input  wire logic [2:0]                  arprot,
	input  wire logic                        arvalid,
	output logic                             arready,
	output logic [31:0]                      rdata,
	output logic [1:0]                       rresp,
	output logic                             rvalid,
	input  wire logic                        rready,
	input  wire logic [6:0]                  scan_addr,
	output logic [7:0]                       scan_data,
	output char_display_pkg::disp_cfg_s      disp_cfg,
	output logic [6:0]                       display_shift,
	output logic                             busy_indicator,
	output logic [3:0]                       glyph_rows,
	output logic                             font_table_valid
);

	// ----------------------------------------------------------------
	// scaled clear run length, counter width and elaboration check
	// ----------------------------------------------------------------
	localparam int unsigned CLEAR_RUN =
		CLEAR_CYCLES * char_display_pkg::REF_OSC_KHZ / OSC_KHZ;
	localparam int unsigned CNT_W     = $clog2(CLEAR_RUN + 1);

	if (OSC_KHZ == 0 || EXEC_CYCLES < 2 ||
		CLEAR_RUN < char_display_pkg::DISPLAY_DATA_RAM_DEPTH) begin : g_bad_param
		$error("unsupported oscillator or run length parameters");
	end

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	char_display_pkg::exec_state_e state_q, state_d;
	char_display_pkg::disp_cfg_s   cfg_q;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [7:0]  display_data_ram_q [char_display_pkg::DISPLAY_DATA_RAM_DEPTH];
	logic [7:0]  glyph_q [char_display_pkg::GLYPH_DEPTH];
	logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic        aw_have_q, w_have_q, wstrb0_q;
	logic [11:0] awaddr_q;
	logic [7:0]  wdata_q;
	logic        wr_phase_q, rd_phase_q;
	logic [3:0]  wr_nib_q;
	logic [7:0]  rd_hold_q;
	logic [7:0]  instruction_holding_reg_q, data_holding_reg_q;
	logic        instr_go_q, data_go_q;
	logic [6:0]  address_pointer_q, shift_q;
	logic        ram_sel_q, step_pend_q, shift_pend_q, busy_q;
	logic [7:0]  fill_q, scan_data_q;
	logic [3:0]  glyph_rows_q;
	logic        font_valid_q;
	logic        do_wr, wr_map, wr_lane, wr_full, wr_take, wr_is_instr;
	logic        wide, blocked, start_clear, start_short, done;
	logic [7:0]  wr_byte;
	logic        ar_fire, rd_is_status, rd_is_data, rd_is_cfg;
	logic        rd_phase1, rd_take;
	logic [7:0]  rd_full;
	logic [11:0] rd_addr;
	logic        dec_clear, dec_home, dec_entry, dec_disp, dec_shift;
	logic        dec_mode, dec_func, dec_glyph, dec_display_data_ram;

	function automatic logic [6:0] step_addr(input logic [6:0] a,
		input logic up, input logic glyph);
		logic [6:0] n;
		n = up ? a + 7'h01 : a - 7'h01;
		return glyph ? {1'b0, n[5:0]} : n;
	endfunction : step_addr

	assign awready          = awready_q;
	assign wready           = wready_q;
	assign bvalid           = bvalid_q;
	assign bresp            = bresp_q;
	assign arready          = arready_q;
	assign rvalid           = rvalid_q;
	assign rresp            = rresp_q;
	assign rdata            = rdata_q;
	assign scan_data        = scan_data_q;
	assign disp_cfg         = cfg_q;
	assign display_shift    = shift_q;
	assign busy_indicator   = busy_q;
	assign glyph_rows       = glyph_rows_q;
	assign font_table_valid = font_valid_q;

	// ----------------------------------------------------------------
	// axi write channels
	// ----------------------------------------------------------------
	assign do_wr  = aw_have_q & w_have_q & ~bvalid_q;
	assign wr_map = (awaddr_q == char_display_pkg::OFS_INSTR) |
		(awaddr_q == char_display_pkg::OFS_DATA);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= 12'h000;
			wdata_q   <= 8'h00;
			wstrb0_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= char_display_pkg::RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready_q)
			begin
				aw_have_q <= 1'b1;
				awready_q <= 1'b0;
				awaddr_q  <= awaddr & ~12'h003;
			end
			if (wvalid && wready_q)
			begin
				w_have_q <= 1'b1;
				wready_q <= 1'b0;
				wdata_q  <= wdata[7:0];
				wstrb0_q <= wstrb[0];
			end
			if (do_wr)
			begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_map ? char_display_pkg::RESP_OKAY
					: char_display_pkg::RESP_SLVERR;
			end
			if (bvalid_q && bready)
			begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// byte assembly and holding registers
	// ----------------------------------------------------------------
	assign wide        = cfg_q.bus_width_select;
	assign blocked     = busy_q | instr_go_q | data_go_q;
	assign wr_lane     = do_wr & wr_map & wstrb0_q;
	assign wr_is_instr = awaddr_q == char_display_pkg::OFS_INSTR;
	assign wr_full     = wr_lane & (wide | wr_phase_q);
	assign wr_byte     = wide ? wdata_q : {wr_nib_q, wdata_q[7:4]};
	assign wr_take     = wr_full & ~blocked;
	assign start_clear = wr_take & wr_is_instr &
		(wr_byte == char_display_pkg::CMD_CLEAR);
	assign start_short = (wr_take & ~start_clear) | rd_take;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_phase_q <= 1'b0;
			wr_nib_q   <= 4'h0;
		end
		else if (wide)
			wr_phase_q <= 1'b0;
		else if (wr_lane && !blocked)
		begin
			wr_phase_q <= ~wr_phase_q;
			if (!wr_phase_q)
				wr_nib_q <= wdata_q[7:4];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			instruction_holding_reg_q <= 8'h00;
			data_holding_reg_q        <= 8'h00;
			instr_go_q                <= 1'b0;
			data_go_q                 <= 1'b0;
		end
		else
		begin
			instr_go_q <= wr_take & wr_is_instr;
			data_go_q  <= wr_take & ~wr_is_instr;
			if (wr_take && wr_is_instr)
				instruction_holding_reg_q <= wr_byte;
			if (wr_take && !wr_is_instr)
				data_holding_reg_q <= wr_byte;
		end
	end

	// ----------------------------------------------------------------
	// instruction decode
	// ----------------------------------------------------------------
	always_comb
	begin
		dec_clear = 1'b0;
		dec_home  = 1'b0;
		dec_entry = 1'b0;
		dec_disp  = 1'b0;
		dec_shift = 1'b0;
		dec_mode  = 1'b0;
		dec_func  = 1'b0;
		dec_glyph = 1'b0;
		dec_display_data_ram = 1'b0;
		if (instr_go_q)
		begin
			casez (instruction_holding_reg_q)
				8'b1???????: dec_display_data_ram = 1'b1;
				8'b01??????: dec_glyph = 1'b1;
				8'b001?????: dec_func  = 1'b1;
				8'b0001??11: dec_mode  = 1'b1;
				8'b0001??00: dec_shift = 1'b1;
				8'b00001???: dec_disp  = 1'b1;
				8'b000001??: dec_entry = 1'b1;
				8'b0000001?: dec_home  = 1'b1;
				8'b00000001: dec_clear = 1'b1;
				default:     dec_clear = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// execution timing
	// ----------------------------------------------------------------
	assign done = (state_q != char_display_pkg::EX_IDLE) && (cnt_q == '0);

	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			char_display_pkg::EX_IDLE:
			begin
				if (start_clear)
				begin
					state_d = char_display_pkg::EX_CLEAR;
					cnt_d   = CNT_W'(CLEAR_RUN - 1);
				end
				else if (start_short)
				begin
					state_d = char_display_pkg::EX_BUSY;
					cnt_d   = CNT_W'(EXEC_CYCLES - 1);
				end
			end
			char_display_pkg::EX_CLEAR, char_display_pkg::EX_BUSY:
			begin
				if (cnt_q == '0)
					state_d = char_display_pkg::EX_IDLE;
				else
					cnt_d = cnt_q - CNT_W'(1);
			end
			default: state_d = char_display_pkg::EX_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= char_display_pkg::EX_IDLE;
			cnt_q   <= '0;
			busy_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			busy_q  <= state_d != char_display_pkg::EX_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// settings
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cfg_q <= char_display_pkg::RST_CFG;
		else
		begin
			if (dec_clear)
				cfg_q.step_direction <= 1'b1;
			if (dec_entry)
			begin
				cfg_q.step_direction <= instruction_holding_reg_q[1];
				cfg_q.shift_on_entry <= instruction_holding_reg_q[0];
			end
			if (dec_disp)
			begin
				cfg_q.display_on <= instruction_holding_reg_q[2];
				cfg_q.cursor_on  <= instruction_holding_reg_q[1];
				cfg_q.blink_on   <= instruction_holding_reg_q[0];
			end
			if (dec_mode)
			begin
				cfg_q.graphic_or_text_mode <=
					instruction_holding_reg_q[3];
				cfg_q.internal_supply_on <=
					instruction_holding_reg_q[2];
			end
			if (dec_func)
			begin
				cfg_q.bus_width_select <= instruction_holding_reg_q[4];
				cfg_q.line_count       <= instruction_holding_reg_q[3];
				cfg_q.glyph_height     <= instruction_holding_reg_q[2];
				cfg_q.font_table       <= instruction_holding_reg_q[1:0];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			glyph_rows_q <= char_display_pkg::ROWS_SHORT;
			font_valid_q <= 1'b1;
		end
		else
		begin
			glyph_rows_q <= cfg_q.glyph_height ? char_display_pkg::ROWS_TALL
				: char_display_pkg::ROWS_SHORT;
			font_valid_q <= cfg_q.font_table != char_display_pkg::FT_NONE;
		end
	end

	// ----------------------------------------------------------------
	// address pointer and ram select
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			address_pointer_q <= 7'h00;
			ram_sel_q         <= 1'b0;
			step_pend_q       <= 1'b0;
		end
		else
		begin
			if (dec_clear || dec_home)
			begin
				address_pointer_q <= 7'h00;
				ram_sel_q         <= 1'b0;
			end
			else if (dec_display_data_ram)
			begin
				address_pointer_q <= instruction_holding_reg_q[6:0];
				ram_sel_q         <= 1'b0;
			end
			else if (dec_glyph)
			begin
				address_pointer_q <= {1'b0, instruction_holding_reg_q[5:0]};
				ram_sel_q         <= 1'b1;
			end
			else if (dec_shift && !instruction_holding_reg_q[3])
				address_pointer_q <= step_addr(address_pointer_q,
					instruction_holding_reg_q[2], ram_sel_q);
			if (data_go_q || rd_take)
				step_pend_q <= 1'b1;
			else if (done && step_pend_q)
			begin
				step_pend_q       <= 1'b0;
				address_pointer_q <= step_addr(address_pointer_q,
					cfg_q.step_direction, ram_sel_q);
			end
		end
	end

	// ----------------------------------------------------------------
	// display shift
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			shift_q      <= 7'h00;
			shift_pend_q <= 1'b0;
		end
		else
		begin
			if (dec_clear || dec_home)
				shift_q <= 7'h00;
			else if (dec_shift && instruction_holding_reg_q[3])
				shift_q <= instruction_holding_reg_q[2] ? shift_q - 7'h01
					: shift_q + 7'h01;
			if (data_go_q)
				shift_pend_q <= 1'b1;
			else if (done && shift_pend_q)
			begin
				shift_pend_q <= 1'b0;
				if (cfg_q.shift_on_entry)
					shift_q <= cfg_q.step_direction ? shift_q + 7'h01
						: shift_q - 7'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// display and glyph ram
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			fill_q <= 8'h80;
		else if (start_clear)
			fill_q <= 8'h00;
		else if (state_q == char_display_pkg::EX_CLEAR && !fill_q[7])
			fill_q <= fill_q + 8'h01;
	end

	always_ff @(posedge aclk)
	begin
		if (state_q == char_display_pkg::EX_CLEAR && !fill_q[7])
			display_data_ram_q[fill_q[6:0]] <= char_display_pkg::BLANK_CODE;
		else if (data_go_q && !ram_sel_q)
			display_data_ram_q[address_pointer_q] <= data_holding_reg_q;
	end

	always_ff @(posedge aclk)
	begin
		if (data_go_q && ram_sel_q)
			glyph_q[address_pointer_q[5:0]] <= data_holding_reg_q;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			scan_data_q <= 8'h00;
		else
			scan_data_q <= display_data_ram_q[scan_addr];
	end

	// ----------------------------------------------------------------
	// axi read channels
	// ----------------------------------------------------------------
	assign ar_fire      = arvalid & arready_q;
	assign rd_addr      = araddr & ~12'h003;
	assign rd_is_status = rd_addr == char_display_pkg::OFS_INSTR;
	assign rd_is_data   = rd_addr == char_display_pkg::OFS_DATA;
	assign rd_is_cfg    = rd_addr == char_display_pkg::OFS_CFG;
	assign rd_phase1    = ~wide & rd_phase_q;
	assign rd_take      = ar_fire & rd_is_data & ~rd_phase1 &
		~blocked & ~wr_take;

	always_comb
	begin
		rd_full = 8'h00;
		if (rd_is_status)
			rd_full = {busy_q, address_pointer_q};
		else if (rd_take)
			rd_full = ram_sel_q ? glyph_q[address_pointer_q[5:0]]
				: display_data_ram_q[address_pointer_q];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q  <= 1'b1;
			rvalid_q   <= 1'b0;
			rdata_q    <= 32'h00000000;
			rresp_q    <= char_display_pkg::RESP_OKAY;
			rd_phase_q <= 1'b0;
			rd_hold_q  <= 8'h00;
		end
		else
		begin
			if (wide)
				rd_phase_q <= 1'b0;
			if (ar_fire)
			begin
				arready_q <= 1'b0;
				rvalid_q  <= 1'b1;
				rresp_q   <= (rd_is_status | rd_is_data | rd_is_cfg)
					? char_display_pkg::RESP_OKAY
					: char_display_pkg::RESP_SLVERR;
				if (rd_is_cfg)
					rdata_q <= {9'h000, shift_q, 3'h0, ram_sel_q, cfg_q};
				else if (!(rd_is_status || rd_is_data))
					rdata_q <= 32'h00000000;
				else if (wide)
					rdata_q <= {24'h000000, rd_full};
				else if (rd_phase1)
				begin
					rdata_q    <= {24'h000000, rd_hold_q[3:0], 4'h0};
					rd_phase_q <= 1'b0;
				end
				else
				begin
					rdata_q   <= {24'h000000, rd_full[7:4], 4'h0};
					rd_hold_q <= rd_full;
					if (rd_is_status || rd_take)
						rd_phase_q <= 1'b1;
				end
			end
			if (rvalid_q && rready)
			begin
				rvalid_q  <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

endmodule : char_display_instruction_decoder

// ==== verification/char_display_properties.sv ====
`timescale 1ns/1ns
module char_display_properties (
	input logic                       aclk,
	input logic                       aresetn,
	input logic                       awvalid,
	input logic                       awready,
	input logic                       wvalid,
	input logic                       wready,
	input logic                       bvalid,
	input logic                       arvalid,
	input logic                       arready,
	input logic                       rvalid,
	input char_display_pkg::disp_cfg_s disp_cfg,
	input logic [6:0]                 display_shift,
	input logic                       busy_indicator,
	input logic [3:0]                 glyph_rows,
	input logic                       font_table_valid
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_busy_run;
		busy_indicator [*4];
	endsequence

	property p_wr_resp;
		s_wr_take |-> ##2 bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp)
		else $error("write answer late");
	property p_aw_take;
		s_wr_take |=> !awready && !wready;
	endproperty
	a_aw_take: assert property (p_aw_take)
		else $error("ready kept after take");
	property p_rd_resp;
		arvalid && arready |=> rvalid && !arready;
	endproperty
	a_rd_resp: assert property (p_rd_resp)
		else $error("read answer late");
	property p_busy_len;
		$rose(busy_indicator) |-> s_busy_run;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("busy too short");
	property p_cfg_busy;
		$changed(disp_cfg) |-> busy_indicator;
	endproperty
	a_cfg_busy: assert property (p_cfg_busy)
		else $error("setting changed while idle");
	property p_shift_busy;
		$changed(display_shift) |-> busy_indicator || $fell(busy_indicator);
	endproperty
	a_shift_busy: assert property (p_shift_busy)
		else $error("shift changed while idle");
	property p_rows;
		glyph_rows == ($past(disp_cfg.glyph_height) ?
			char_display_pkg::ROWS_TALL : char_display_pkg::ROWS_SHORT);
	endproperty
	a_rows: assert property (p_rows)
		else $error("glyph rows wrong");
	property p_font;
		font_table_valid == ($past(disp_cfg.font_table) != 2'h3);
	endproperty
	a_font: assert property (p_font)
		else $error("font valid wrong");
endmodule : char_display_properties

bind char_display_instruction_decoder char_display_properties props_i (
	.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
	.arvalid, .arready, .rvalid, .disp_cfg, .display_shift,
	.busy_indicator, .glyph_rows, .font_table_valid);

// ==== verification/char_display_host.sv ====
`timescale 1ns/1ns
module char_display_host (
	input  logic        aclk,
	output logic [11:0] awaddr,
	output logic        awvalid,
	input  logic        awready,
	output logic [31:0] wdata,
	output logic        wvalid,
	input  logic        wready,
	input  logic [1:0]  bresp,
	input  logic        bvalid,
	output logic        bready,
	output logic [11:0] araddr,
	output logic        arvalid,
	input  logic        arready,
	input  logic [31:0] rdata,
	input  logic [1:0]  rresp,
	input  logic        rvalid,
	output logic        rready
);
	int to = 0;
	initial
	begin
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready && awvalid) awvalid <= 1'b0;
			if (wready && wvalid) wvalid <= 1'b0;
			n++;
		end while (!bvalid && n < 2000);
		resp = bresp;
		bready <= 1'b0;
		if (!bvalid) to++;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready && arvalid) arvalid <= 1'b0;
			n++;
		end while (!rvalid && n < 2000);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (!rvalid) to++;
	endtask : rd
endmodule : char_display_host

// ==== verification/test_char_display_instruction_decoder.sv ====
`timescale 1ns/1ns
module test_char_display_instruction_decoder;
	logic aclk = 0, aresetn = 0;
	logic [6:0] scan_addr = '0;
	logic [11:0] awaddr, araddr, cfg;
	logic [31:0] wdata, rdata, rv;
	logic [1:0] bresp, rresp, rs;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, busy_indicator, font_table_valid;
	logic [7:0] scan_data, b;
	logic [6:0] display_shift;
	logic [3:0] glyph_rows;
	char_display_pkg::disp_cfg_s disp_cfg;
	int n_mismatch = 0, tests_run = 0;
	int mem[128], gmem[64], ptr, sh, gsel, i, k;
	always #5 aclk = ~aclk;

	char_display_instruction_decoder #(.CLEAR_CYCLES(200))
	char_display_instruction_decoder_i (.aclk, .aresetn, .awaddr,
		.awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .scan_addr, .scan_data,
		.disp_cfg, .display_shift, .busy_indicator, .glyph_rows,
		.font_table_valid);
	char_display_host host_i (.aclk, .awaddr, .awvalid, .awready, .wdata,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready);

	// ----------------------------------------------------------------
	// checking and bus helpers
	// ----------------------------------------------------------------
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	task automatic chk32(logic [31:0] g, logic [31:0] e);
		tests_run++;
		if (g !== e) n_mismatch++;
		if (g !== e) $display("ERROR %0t got %h want %h", $time, g, e);
	endtask : chk32
	task automatic chk2(logic [1:0] g, logic [1:0] e);
		tests_run++;
		if (g !== e) n_mismatch++;
		if (g !== e) $display("ERROR %0t response %h", $time, g);
	endtask : chk2
	task automatic hang;
		n_mismatch++;
		$display("ERROR %0t bus or busy wait timed out", $time);
		report_and_stop;
	endtask : hang
	task automatic w(logic [11:0] a, logic [7:0] d);
		logic nib;
		nib = !cfg[11] && a < 12'h008;
		if (nib) host_i.wr(a, {24'h0, d[7:4], 4'h0}, rs);
		host_i.wr(a, {24'h0, nib ? {d[3:0], 4'h0} : d}, rs);
		if (host_i.to != 0) hang;
	endtask : w
	task automatic r(logic [11:0] a);
		logic [31:0] hi;
		host_i.rd(a, rv, rs);
		if (!cfg[11] && a < 12'h008)
		begin
			hi = rv;
			host_i.rd(a, rv, rs);
			rv = {24'h0, hi[7:4], rv[7:4]};
		end
		if (host_i.to != 0) hang;
	endtask : r
	task automatic idle;
		k = 0;
		do
		begin
			r(12'h000);
			k++;
		end while (rv[7] !== 1'b0 && k < 500);
		if (rv[7] !== 1'b0) hang;
	endtask : idle
	task automatic chkst;
		r(12'h008);
		chk32(rv, {9'h0, sh[6:0], 3'h0, gsel[0], cfg});
		r(12'h000);
		chk32(rv, {25'h0, ptr[6:0]});
	endtask : chkst

	// ----------------------------------------------------------------
	// reference model
	// ----------------------------------------------------------------
	task automatic step;
		ptr = (cfg[1] ? ptr + 1 : ptr - 1) & (gsel ? 63 : 127);
	endtask : step
	task automatic cmd(logic [7:0] c);
		w(12'h000, c);
		if (c[7]) {gsel, ptr} = {32'h0, 25'h0, c[6:0]};
		else if (c[6]) {gsel, ptr} = {32'h1, 26'h0, c[5:0]};
		else if (c[5]) cfg[11:7] = c[4:0];
		else if (c[4] && c[1:0] == 2'h3) cfg[6:5] = c[3:2];
		else if (c[4] && c[1:0] == 2'h0 && c[3]) sh += c[2] ? -1 : 1;
		else if (c[4] && c[1:0] == 2'h0)
			ptr = (c[2] ? ptr + 1 : ptr - 1) & (gsel ? 63 : 127);
		else if (c[3]) cfg[4:2] = c[2:0];
		else if (c[2]) cfg[1:0] = c[1:0];
		else if (c[1]) {gsel, ptr, sh} = '0;
		else if (c[0])
		begin
			{gsel, ptr, sh} = '0;
			cfg[1] = 1'b1;
			foreach (mem[j]) mem[j] = 32'h20;
		end
		sh &= 127;
		// model first, so the busy poll already uses the new bus width
		idle;
		chkst;
	endtask : cmd
	task automatic dw(logic [7:0] d);
		w(12'h004, d);
		idle;
		if (gsel) gmem[ptr] = d;
		else mem[ptr] = d;
		if (cfg[0]) sh = (sh + (cfg[1] ? 1 : -1)) & 127;
		step;
		chkst;
	endtask : dw
	task automatic dr;
		r(12'h004);
		chk32(rv, gsel ? gmem[ptr] : mem[ptr]);
		idle;
		step;
		chkst;
	endtask : dr

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		{ptr, sh, gsel} = '0;
		cfg = 12'h802;
		void'($urandom(39438));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		chkst;
		cmd(8'h01);
		for (i = 0; i < 40; i++)
		begin
			b = 8'($urandom);
			case (i % 8)
				0: cmd(8'h04 | b[1:0]);
				1: cmd(8'h08 | b[2:0]);
				2: cmd(8'h10 | (b & 8'h0c));
				3: cmd(8'h13 | (b & 8'h0c));
				4: cmd(8'h30 | b[3:0]);
				5: cmd(8'h40 | b[5:0]);
				6: cmd(8'h80 | b[6:0]);
				default: cmd(8'h02);
			endcase
			dw(8'($urandom));
		end
		cmd(8'h06);
		for (k = 0; k < 2; k++)
		begin
			cmd(k ? 8'h4c : 8'hfe);
			for (i = 0; i < 4; i++) dw(8'($urandom));
			cmd(k ? 8'h4c : 8'hfe);
			for (i = 0; i < 4; i++) dr;
		end
		w(12'h000, 8'h85);
		w(12'h004, 8'h5a);
		idle;
		ptr = 5;
		gsel = 0;
		chkst;
		dr;
		r(12'h010);
		chk2(rs, char_display_pkg::RESP_SLVERR);
		w(12'h008, 8'h00);
		chk2(rs, char_display_pkg::RESP_SLVERR);
		chkst;
		// nibble transfers: write and read back one byte, then back to 8-bit
		cmd(8'h2e);
		cmd(8'h8a);
		dw(8'($urandom));
		cmd(8'h8a);
		dr;
		cmd(8'h3c);
		for (i = 0; i < 8; i++)
		begin
			@(posedge aclk) scan_addr <= 7'(i * 17);
			repeat (2) @(posedge aclk);
			chk32({24'h0, scan_data}, mem[i * 17]);
		end
		report_and_stop;
	end
endmodule : test_char_display_instruction_decoder
